// ===== common/smseq_defs.vh
// Constants for the SMBus master transfer sequencer: register offsets,
// field positions, reset values, status codes and bus timing.
// Assumes APB byte addresses with one aligned 32-bit word per register.
`ifndef SMSEQ_DEFS_VH
`define SMSEQ_DEFS_VH

// Register byte offsets.
`define SMSEQ_OFF_CTRL 8'h00
`define SMSEQ_OFF_STAT 8'h04
`define SMSEQ_OFF_DATA 8'h08
`define SMSEQ_OFF_IRQS 8'h0C
`define SMSEQ_OFF_IRQM 8'h10

// Control register fields.
`define SMSEQ_CTRL_EN 0
`define SMSEQ_CTRL_HWACK 1
`define SMSEQ_CTRL_STA 2
`define SMSEQ_CTRL_STO 3
`define SMSEQ_CTRL_ACK 4
`define SMSEQ_CTRL_SI 5
`define SMSEQ_CTRL_RST 32'h00000002

// Status register fields.
`define SMSEQ_STAT_VEC_HI 3
`define SMSEQ_STAT_ACK_REQUEST_FLAG 4
`define SMSEQ_STAT_ARBITRATION_LOST_FLAG 5
`define SMSEQ_STAT_MASTER 6
`define SMSEQ_STAT_BUSY 7

// Interrupt status and mask fields.
`define SMSEQ_IRQ_FRAME 0
`define SMSEQ_IRQ_STOP 1
`define SMSEQ_IRQ_RST 2'h0

// Status vector codes.
`define SMSEQ_SV_IDLE 4'h0
`define SMSEQ_SV_START 4'hE
`define SMSEQ_SV_MTX 4'hC
`define SMSEQ_SV_MRX 4'h8

// Quarter of a serial clock period, in ns, and the system clock rate.
`define SMSEQ_QTR_NS 2500
`define SMSEQ_CLK_MHZ 200
`define SMSEQ_QTR_CYC ((`SMSEQ_QTR_NS * `SMSEQ_CLK_MHZ) / 1000)

`endif

// ===== design/smseq_sync.v
// Three-stage synchroniser for a pin that changes outside pclk.
// Assumes presetn is asynchronous and active low; idle level is high.
`timescale 1ns/10ps
module smseq_sync (
  input wire pclk, // System clock.
  input wire presetn, // Asynchronous reset, active low.
  input wire din, // Raw pin level.
  output reg dout // Filtered level, changes once stages two and three agree.
);

  reg s1_ff;
  reg s2_ff;
  reg s3_ff;

  // The first stage feeds only the second; the output moves on agreement.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= 1'b1;
      s2_ff <= 1'b1;
      s3_ff <= 1'b1;
      dout <= 1'b1;
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        dout <= s3_ff;
      end
    end
  end

endmodule // smseq_sync

// ===== design/smseq_tick.v
// Divider giving a one-cycle enable pulse every quarter serial bit.
// Assumes a single pclk domain; restarts when clr is high.
`timescale 1ns/10ps
module smseq_tick #(
  parameter [15:0] DIV = 16'd500 // Cycles per quarter bit.
) (
  input wire pclk, // System clock.
  input wire presetn, // Asynchronous reset, active low.
  input wire clr, // Restart the count.
  output reg tick // One-cycle pulse each quarter bit.
);

  reg [15:0] cnt_ff;

  // Counting down keeps the compare to a constant zero.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 16'h0000;
      tick <= 1'b0;
    end else if (clr) begin
      cnt_ff <= DIV - 16'd1;
      tick <= 1'b0;
    end else if (cnt_ff == 16'h0000) begin
      cnt_ff <= DIV - 16'd1;
      tick <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff - 16'd1;
      tick <= 1'b0;
    end
  end

endmodule // smseq_tick

// ===== design/smseq_top.v
// SMBus master transfer sequencer with an APB register slave.
// Assumes one pclk domain, open-drain pins resolved outside, slaves per SMBus.
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/10ps
`include "smseq_defs.vh"
module smseq_top #(
  parameter [15:0] QTR_CYC = `SMSEQ_QTR_CYC // Cycles per quarter serial bit.
) (
  input wire pclk, // System clock, 200 MHz.
  input wire presetn, // Asynchronous reset, active low.
  input wire psel, // APB select.
  input wire penable, // APB enable.
  input wire pwrite, // APB direction, high for write.
  input wire [7:0] paddr, // APB byte address.
  input wire [31:0] pwdata, // APB write data.
  output reg [31:0] prdata, // APB read data.
  output reg pready, // APB ready.
  output reg pslverr, // APB error for unmapped address.
  input wire scl_i, // Serial clock pin level.
  output reg scl_o, // Serial clock output value, always low.
  output reg scl_oe, // High while pulling serial clock low.
  input wire sda_i, // Serial data pin level.
  output reg sda_o, // Serial data output value, always low.
  output reg sda_oe, // High while pulling serial data low.
  output reg irq // Level interrupt, high while an unmasked event is pending.
);

  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_START = 7'h02;
  localparam [6:0] S_BIT = 7'h04;
  localparam [6:0] S_ACK = 7'h08;
  localparam [6:0] S_HOLD = 7'h10;
  localparam [6:0] S_DEC = 7'h20;
  localparam [6:0] S_STOP = 7'h40;

  reg [6:0] state_ff;
  reg [1:0] phase_ff;
  reg [2:0] bitcnt_ff;
  reg [7:0] shift_ff;
  reg [7:0] serial_data_reg_ff;
  reg dwr_ff;
  reg en_ff;
  reg hw_ack_enable_ff;
  reg start_request_bit_ff;
  reg stop_request_bit_ff;
  reg ack_ff;
  reg si_ff;
  reg [3:0] status_ff;
  reg master_ff;
  reg tx_ff;
  reg late_ff;
  reg ack_request_flag_ff;
  reg [1:0] irq_stat_ff;
  reg [1:0] irq_mask_ff;
  wire scl_s;
  wire sda_s;
  wire tick;
  wire acc;
  wire wr;
  wire adv;
  wire si_set;
  wire stop_done;
  wire [31:0] ctrl_rd;
  wire [31:0] stat_rd;
  reg [31:0] nxt_prdata;
  reg nxt_err;

  // Returns true when the address selects one of the mapped words.
  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `SMSEQ_OFF_CTRL) || (a == `SMSEQ_OFF_STAT) ||
               (a == `SMSEQ_OFF_DATA) || (a == `SMSEQ_OFF_IRQS) ||
               (a == `SMSEQ_OFF_IRQM);
    end
  endfunction

  smseq_sync u_scl_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(scl_i),
    .dout(scl_s)
  );

  smseq_sync u_sda_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(sda_i),
    .dout(sda_s)
  );

  // Holding the divider in clear in S_IDLE, S_HOLD and S_DEC aligns the first quarter.
  smseq_tick #(
    .DIV(QTR_CYC)
  ) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .clr(state_ff == S_IDLE || state_ff == S_HOLD || state_ff == S_DEC),
    .tick(tick)
  );

  // APB answers one cycle into the access phase; writes land with pready.
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite && mapped(paddr);

  // Phase two waits for SCL to read high, which honours clock stretching.
  assign adv = tick && (phase_ff != 2'd2 || scl_s);

  // Hardware-set events; each wins over a clear in the same cycle.
  assign si_set = adv && phase_ff == 2'd3 &&
                  ((state_ff == S_START) ||
                   (state_ff == S_ACK && !late_ff) ||
                   (state_ff == S_BIT && bitcnt_ff == 3'd7 && !tx_ff &&
                    !hw_ack_enable_ff));
  assign stop_done = adv && phase_ff == 2'd3 && state_ff == S_STOP;

  assign ctrl_rd = {26'h0000000, si_ff, ack_ff, stop_request_bit_ff,
                    start_request_bit_ff, hw_ack_enable_ff, en_ff};
  // Arbitration is not contested here, so that flag reads zero.
  assign stat_rd = {24'h000000, (state_ff != S_IDLE), master_ff, 1'b0,
                    ack_request_flag_ff, status_ff};

  // Read data mux and unmapped-address error.
  always @* begin
    nxt_err = !mapped(paddr);
    case (paddr)
      `SMSEQ_OFF_CTRL: nxt_prdata = ctrl_rd;
      `SMSEQ_OFF_STAT: nxt_prdata = stat_rd;
      `SMSEQ_OFF_DATA: nxt_prdata = {24'h000000, serial_data_reg_ff};
      `SMSEQ_OFF_IRQS: nxt_prdata = {30'h00000000, irq_stat_ff};
      `SMSEQ_OFF_IRQM: nxt_prdata = {30'h00000000, irq_mask_ff};
      default: nxt_prdata = 32'h00000000;
    endcase
  end

  // APB slave handshake, registered so every output comes from a flop.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready) begin
        prdata <= pwrite ? 32'h00000000 : nxt_prdata;
        pslverr <= nxt_err;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // Sticky interrupt status, write one to clear, and the masked output.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_ff <= `SMSEQ_IRQ_RST;
      irq_mask_ff <= `SMSEQ_IRQ_RST;
      irq <= 1'b0;
    end else begin
      if (wr && paddr == `SMSEQ_OFF_IRQM) begin
        irq_mask_ff <= pwdata[1:0];
      end
      irq_stat_ff[`SMSEQ_IRQ_FRAME] <= si_set ||
        (irq_stat_ff[`SMSEQ_IRQ_FRAME] &&
         !(wr && paddr == `SMSEQ_OFF_IRQS && pwdata[`SMSEQ_IRQ_FRAME]));
      irq_stat_ff[`SMSEQ_IRQ_STOP] <= stop_done ||
        (irq_stat_ff[`SMSEQ_IRQ_STOP] &&
         !(wr && paddr == `SMSEQ_OFF_IRQS && pwdata[`SMSEQ_IRQ_STOP]));
      irq <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  // Software control bits and the data register; the sequencer clears
  // the start and stop requests once it has acted on them.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_ff <= 1'b0;
      hw_ack_enable_ff <= 1'b1;
      start_request_bit_ff <= 1'b0;
      stop_request_bit_ff <= 1'b0;
      ack_ff <= 1'b0;
      si_ff <= 1'b0;
      serial_data_reg_ff <= 8'h00;
      dwr_ff <= 1'b0;
    end else begin
      if (wr && paddr == `SMSEQ_OFF_CTRL) begin
        en_ff <= pwdata[`SMSEQ_CTRL_EN];
        hw_ack_enable_ff <= pwdata[`SMSEQ_CTRL_HWACK];
        start_request_bit_ff <= pwdata[`SMSEQ_CTRL_STA];
        stop_request_bit_ff <= pwdata[`SMSEQ_CTRL_STO];
        ack_ff <= pwdata[`SMSEQ_CTRL_ACK];
      end else begin
        if (state_ff == S_START && adv && phase_ff == 2'd3) begin
          start_request_bit_ff <= 1'b0;
        end
        if (stop_done || (state_ff == S_IDLE && stop_request_bit_ff &&
                          !start_request_bit_ff)) begin
          stop_request_bit_ff <= 1'b0;
        end
        // Transmit: the slave's answer lands in the ack bit.
        if (state_ff == S_ACK && tx_ff && adv && phase_ff == 2'd2) begin
          ack_ff <= !sda_s;
        end
      end
      // Only a zero clears the flag; the hardware set takes priority.
      if (si_set) begin
        si_ff <= 1'b1;
      end else if (wr && paddr == `SMSEQ_OFF_CTRL && !pwdata[`SMSEQ_CTRL_SI]) begin
        si_ff <= 1'b0;
      end
      if (wr && paddr == `SMSEQ_OFF_DATA) begin
        serial_data_reg_ff <= pwdata[7:0];
        dwr_ff <= 1'b1;
      end else begin
        if (state_ff == S_DEC) begin
          dwr_ff <= 1'b0;
        end
        if (state_ff == S_ACK && !tx_ff && adv && phase_ff == 2'd0 && !late_ff) begin
          serial_data_reg_ff <= shift_ff;
        end else if (state_ff == S_BIT && !tx_ff && !hw_ack_enable_ff &&
                     adv && phase_ff == 2'd3 && bitcnt_ff == 3'd7) begin
          serial_data_reg_ff <= shift_ff;
        end
      end
    end
  end

  // Transfer sequencer: each bit is four quarter phases of the divider.
  // Phase 0 sets SDA with SCL low, 1 releases SCL, 2 samples with SCL
  // high, 3 pulls SCL low again.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= S_IDLE;
      phase_ff <= 2'd0;
      bitcnt_ff <= 3'd0;
      shift_ff <= 8'h00;
      status_ff <= `SMSEQ_SV_IDLE;
      master_ff <= 1'b0;
      tx_ff <= 1'b0;
      late_ff <= 1'b0;
      ack_request_flag_ff <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      if (adv) begin
        phase_ff <= phase_ff + 2'd1;
      end
      case (state_ff)
        S_IDLE: begin
          phase_ff <= 2'd0;
          if (en_ff && start_request_bit_ff && !stop_request_bit_ff) begin
            state_ff <= S_START;
          end
        end
        // START or repeated START: SDA falls while SCL is high.
        S_START: begin
          if (adv) begin
            case (phase_ff)
              2'd0: sda_oe <= 1'b0;
              2'd1: scl_oe <= 1'b0;
              2'd2: sda_oe <= 1'b1;
              default: begin
                scl_oe <= 1'b1;
                master_ff <= 1'b1;
                status_ff <= `SMSEQ_SV_START;
                ack_request_flag_ff <= 1'b0;
                tx_ff <= 1'b1;
                state_ff <= S_HOLD;
              end
            endcase
          end
        end
        S_BIT: begin
          if (adv) begin
            case (phase_ff)
              2'd0: sda_oe <= tx_ff && !shift_ff[7];
              2'd1: scl_oe <= 1'b0;
              2'd2: begin
                if (!tx_ff) begin
                  shift_ff <= {shift_ff[6:0], sda_s};
                end
              end
              default: begin
                scl_oe <= 1'b1;
                bitcnt_ff <= bitcnt_ff + 3'd1;
                if (tx_ff) begin
                  shift_ff <= {shift_ff[6:0], 1'b0};
                end
                if (bitcnt_ff == 3'd7) begin
                  if (!tx_ff && !hw_ack_enable_ff) begin
                    // Without hardware ack the frame stops before the ack bit.
                    late_ff <= 1'b1;
                    ack_request_flag_ff <= 1'b1;
                    status_ff <= `SMSEQ_SV_MRX;
                    state_ff <= S_HOLD;
                  end else begin
                    state_ff <= S_ACK;
                  end
                end
              end
            endcase
          end
        end
        // Ack bit: released when sending, driven from the ack bit when receiving.
        S_ACK: begin
          if (adv) begin
            case (phase_ff)
              2'd0: sda_oe <= !tx_ff && ack_ff;
              2'd1: scl_oe <= 1'b0;
              2'd2: sda_oe <= sda_oe;
              default: begin
                scl_oe <= 1'b1;
                if (late_ff) begin
                  late_ff <= 1'b0;
                  state_ff <= S_DEC;
                end else begin
                  status_ff <= tx_ff ? `SMSEQ_SV_MTX : `SMSEQ_SV_MRX;
                  state_ff <= S_HOLD;
                end
              end
            endcase
          end
        end
        // SCL stays pulled low until software drops the flag.
        S_HOLD: begin
          phase_ff <= 2'd0;
          if (!si_ff) begin
            ack_request_flag_ff <= 1'b0;
            state_ff <= late_ff ? S_ACK : S_DEC;
          end
        end
        // Choose the next step from the request bits and a data write.
        S_DEC: begin
          phase_ff <= 2'd0;
          bitcnt_ff <= 3'd0;
          if (stop_request_bit_ff) begin
            state_ff <= S_STOP;
          end else if (start_request_bit_ff) begin
            state_ff <= S_START;
          end else if (dwr_ff) begin
            shift_ff <= serial_data_reg_ff;
            tx_ff <= 1'b1;
            state_ff <= S_BIT;
          end else begin
            tx_ff <= 1'b0;
            state_ff <= S_BIT;
          end
        end
        // STOP: SDA rises while SCL is high; a pending start follows.
        S_STOP: begin
          if (adv) begin
            case (phase_ff)
              2'd0: sda_oe <= 1'b1;
              2'd1: scl_oe <= 1'b0;
              2'd2: sda_oe <= 1'b0;
              default: begin
                master_ff <= 1'b0;
                status_ff <= `SMSEQ_SV_IDLE;
                state_ff <= start_request_bit_ff ? S_START : S_IDLE;
              end
            endcase
          end
        end
        default: begin
          state_ff <= S_IDLE;
        end
      endcase
    end
  end

endmodule // smseq_top

// ===== tb/smseq_checker.sv
// Port-level assertions for the SMBus master sequencer.
// Assumes it is bound to smseq_top and sees only that module's ports.
`timescale 1ns/10ps
`include "smseq_defs.vh"
module smseq_checker #(
  parameter [15:0] QTR_CYC = 16'd500 // Cycles per quarter serial bit.
) (
  input wire pclk, // System clock.
  input wire presetn, // Asynchronous reset, active low.
  input wire psel, // APB select.
  input wire penable, // APB enable.
  input wire pwrite, // APB direction.
  input wire [7:0] paddr, // APB address.
  input wire [31:0] pwdata, // APB write data.
  input wire [31:0] prdata, // APB read data.
  input wire pready, // APB ready.
  input wire pslverr, // APB error.
  input wire scl_i, // Serial clock level.
  input wire scl_o, // Serial clock output value.
  input wire scl_oe, // Serial clock pull-down.
  input wire sda_i, // Serial data level.
  input wire sda_o, // Serial data output value.
  input wire sda_oe, // Serial data pull-down.
  input wire irq // Interrupt line.
);
  // Phase three follows phase two after one divider period, so one quarter
  // plus a margin bounds the wait and keeps the range short at any rate.
  localparam int QMAX = QTR_CYC + 2;
  reg hwack_ff; // Hardware ack enable as software last wrote it.
  wire st_rd = psel && penable && pready && !pwrite && (paddr == `SMSEQ_OFF_STAT);
  // Flag checks only hold with hardware ack on, so follow the mode bit.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) hwack_ff <= 1'b1;
    else if (psel && penable && pready && pwrite && paddr == `SMSEQ_OFF_CTRL)
      hwack_ff <= pwdata[`SMSEQ_CTRL_HWACK];
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_timing_a: assert property (psel && $rose(penable) |-> !pready ##1 pready)
    else $error("pready not on second access cycle");
  ready_pulse_a: assert property (pready |-> psel && penable ##1 !pready)
    else $error("pready outside access or longer than one cycle");
  unmapped_err_a: assert property (pready && paddr > 8'h10 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  stat_flags_a: assert property (st_rd && hwack_ff |-> prdata[5:4] == 2'b00)
    else $error("status flags set in master state");
  stat_code_a: assert property (st_rd |-> prdata[3:0] inside {4'h0, 4'h8, 4'hC, 4'hE})
    else $error("unknown status vector");
  start_hold_a: assert property ($rose(sda_oe) && !scl_oe |-> ##[1:QMAX] scl_oe)
    else $error("clock not taken low after start");
  data_stable_a: assert property ($fell(scl_oe) |-> $stable(sda_oe))
    else $error("data moved as clock released");
  stop_idle_a: assert property ($fell(sda_oe) && !scl_oe |=> !scl_oe [*4])
    else $error("clock pulled right after stop");
  reset_idle_a: assert property ($rose(presetn) |-> !scl_oe && !sda_oe && !irq && !scl_o)
    else $error("pins not released after reset");
endmodule // smseq_checker

bind smseq_top smseq_checker #(.QTR_CYC(QTR_CYC)) chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl_i), .scl_o(scl_o),
  .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));

// ===== tb/smseq_slave.sv
// Behavioural SMBus slave: acks its address and written bytes, returns a fixed byte.
// Assumes open-drain wires with pull-ups resolved by the bench.
`timescale 1ns/10ps
module smseq_slave #(
  parameter [6:0] ADDR = 7'h2A, // Own address, arbitrary.
  parameter [7:0] RDATA = 8'hA5, // Byte returned on reads.
  parameter integer STRETCH = 200 // Clock stretch in ns after each frame.
) (
  input wire scl, // Resolved serial clock.
  input wire sda, // Resolved serial data.
  output reg sda_pull, // High while pulling data low.
  output reg scl_pull // High while stretching the clock.
);
  reg [7:0] sh = 8'h00; // Last byte shifted in.
  integer n = 0; // Bit slot in the frame, 8 is the ack slot.
  reg first = 1'b0;
  reg act = 1'b0;
  reg rd = 1'b0;
  initial sda_pull = 1'b0;
  initial scl_pull = 1'b0;
  // Start and stop are data edges with the clock high.
  always @(negedge sda) if (scl === 1'b1) begin
    n = 0;
    first = 1'b1;
    act = 1'b0;
  end
  always @(posedge sda) if (scl === 1'b1) act = 1'b0;
  // Sample on the rising clock; a master nack ends a read.
  always @(posedge scl) begin
    if (n < 8) sh = {sh[6:0], sda};
    else if (rd && sda === 1'b1) act = 1'b0;
    n = (n == 8) ? 0 : n + 1;
  end
  // Drive on the falling clock; stretching slows the master at frame starts.
  always @(negedge scl) begin
    sda_pull = 1'b0;
    if (n == 8 && first) begin
      act = (sh[7:1] == ADDR);
      rd = sh[0];
      first = 1'b0;
      sda_pull = act;
    end else if (n == 8 && !rd) sda_pull = act;
    else if (n < 8 && rd && act) sda_pull = ~RDATA[7 - n];
    if (n == 0) begin
      scl_pull = 1'b1;
      #(STRETCH) scl_pull = 1'b0;
    end
  end
endmodule // smseq_slave

// ===== tb/tb_top.sv
// Self-checking bench for the SMBus sequencer, one task per scenario.
// Assumes a fast quarter-bit divider and the slave model on the wires.
`timescale 1ns/10ps
`include "smseq_defs.vh"
module tb_top;
  localparam [6:0] SLV = 7'h2A;
  localparam [31:0] BASE = 32'h3; // Enable plus hardware ack; t_read turns hardware ack off for one byte.
  localparam [31:0] REQ_START = 32'h4;
  localparam [31:0] REQ_STOP = 32'h8;
  localparam [31:0] ACK_BIT = 32'h10;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0;
  reg [31:0] rdat;
  reg rerr;
  wire [31:0] prdata;
  wire pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, irq, s_sda, s_scl;
  wire scl = ~(scl_oe | s_scl); // Pull-up unless someone pulls low.
  wire sda = ~(sda_oe | s_sda);
  integer err_count = 0;
  integer total_checks = 0;
  always #2.5 pclk = ~pclk;
  smseq_top #(.QTR_CYC(16'd4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));
  smseq_slave #(.ADDR(SLV)) slv (.scl(scl), .sda(sda), .sda_pull(s_sda), .scl_pull(s_scl));
  task check(input string name, input [31:0] seen, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  // One APB transfer; the request holds until pready is sampled high.
  task apb(input [7:0] a, input w, input [31:0] d);
    integer n;
    begin
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
        @(posedge pclk);
        n = n + 1;
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
      if (n == 20) begin
        check("pready timeout", 32'h1, 32'h0);
        report_and_stop;
      end
    end
  endtask
  // Poll a bit until it takes a value; a bounded wait ends the run if it hangs.
  task poll(input [7:0] a, input integer b, input v);
    integer n;
    begin
      n = 0;
      apb(a, 1'b0, 32'h0);
      while (rdat[b] !== v && n < 400) begin
        apb(a, 1'b0, 32'h0);
        n = n + 1;
      end
      if (rdat[b] !== v) begin
        check("poll timeout", 32'h1, 32'h0);
        report_and_stop;
      end
    end
  endtask
  // Write control with the flag cleared, wait for the next frame, compare the status.
  task step(input [31:0] c, input [3:0] v);
    begin
      apb(`SMSEQ_OFF_CTRL, 1'b1, BASE | c);
      poll(`SMSEQ_OFF_CTRL, `SMSEQ_CTRL_SI, 1'b1);
      apb(`SMSEQ_OFF_STAT, 1'b0, 32'h0);
      check("status vector", {28'h0, rdat[3:0]}, {28'h0, v});
      check("clock held low", {31'h0, scl_oe}, 32'h1);
    end
  endtask
  task t_reset;
    begin
      apb(`SMSEQ_OFF_CTRL, 1'b0, 32'h0);
      check("ctrl reset", rdat, `SMSEQ_CTRL_RST);
      apb(`SMSEQ_OFF_STAT, 1'b0, 32'h0);
      check("stat reset", rdat, 32'h0);
      apb(8'h40, 1'b1, 32'hFFFFFFFF);
      check("unmapped error", {31'h0, rerr}, 32'h1);
      apb(`SMSEQ_OFF_IRQS, 1'b0, 32'h0);
      check("irq stat reset", rdat, 32'h0);
    end
  endtask
  // Write two bytes, with the interrupt masked, unmasked and cleared on the way.
  task t_write;
    begin
      step(REQ_START, `SMSEQ_SV_START);
      check("master bit", {31'h0, rdat[6]}, 32'h1);
      check("irq masked", {31'h0, irq}, 32'h0);
      apb(`SMSEQ_OFF_IRQM, 1'b1, 32'h3);
      repeat (2) @(posedge pclk);
      check("irq raised", {31'h0, irq}, 32'h1);
      apb(`SMSEQ_OFF_IRQS, 1'b1, 32'h3);
      repeat (2) @(posedge pclk);
      check("irq cleared", {31'h0, irq}, 32'h0);
      apb(`SMSEQ_OFF_DATA, 1'b1, {24'h0, SLV, 1'b0});
      step(32'h0, `SMSEQ_SV_MTX);
      check("address on wire", {24'h0, slv.sh}, {24'h0, SLV, 1'b0});
      apb(`SMSEQ_OFF_CTRL, 1'b0, 32'h0);
      check("ack seen", {31'h0, rdat[`SMSEQ_CTRL_ACK]}, 32'h1);
      apb(`SMSEQ_OFF_DATA, 1'b1, 32'h3C);
      step(32'h0, `SMSEQ_SV_MTX);
      check("data on wire", {24'h0, slv.sh}, 32'h3C);
      apb(`SMSEQ_OFF_CTRL, 1'b1, BASE | REQ_STOP);
      poll(`SMSEQ_OFF_STAT, `SMSEQ_STAT_MASTER, 1'b0);
      check("idle status", {28'h0, rdat[3:0]}, 32'h0);
      check("open drain values", {30'h0, scl_o, sda_o}, 32'h0);
      check("stop irq", {31'h0, irq}, 32'h1);
      apb(`SMSEQ_OFF_IRQS, 1'b1, 32'h3);
    end
  endtask
  // Nack, restart, then read four bytes and finish with stop plus start.
  task t_read;
    begin
      step(REQ_START, `SMSEQ_SV_START);
      apb(`SMSEQ_OFF_DATA, 1'b1, {24'h0, 7'h11, 1'b1});
      step(32'h0, `SMSEQ_SV_MTX);
      apb(`SMSEQ_OFF_CTRL, 1'b0, 32'h0);
      check("nack seen", {31'h0, rdat[`SMSEQ_CTRL_ACK]}, 32'h0);
      step(REQ_START, `SMSEQ_SV_START);
      apb(`SMSEQ_OFF_DATA, 1'b1, {24'h0, SLV, 1'b1});
      step(32'h0, `SMSEQ_SV_MTX);
      step(ACK_BIT, `SMSEQ_SV_MRX);
      apb(`SMSEQ_OFF_DATA, 1'b0, 32'h0);
      check("first byte", rdat, 32'hA5);
      check("slave still active", {31'h0, slv.act}, 32'h1);
      // Hardware ack off for one byte: the flag comes before the ack bit.
      apb(`SMSEQ_OFF_CTRL, 1'b1, 32'h11);
      poll(`SMSEQ_OFF_CTRL, `SMSEQ_CTRL_SI, 1'b1);
      apb(`SMSEQ_OFF_STAT, 1'b0, 32'h0);
      check("flag before ack", {27'h0, rdat[4:0]}, 32'h18);
      apb(`SMSEQ_OFF_DATA, 1'b0, 32'h0);
      check("early byte", rdat, 32'hA5);
      check("ack still pending", {31'h0, slv.act}, 32'h1);
      step(ACK_BIT, `SMSEQ_SV_MRX);
      step(32'h0, `SMSEQ_SV_MRX);
      apb(`SMSEQ_OFF_DATA, 1'b0, 32'h0);
      check("last byte", rdat, 32'hA5);
      check("master nacked", {31'h0, slv.act}, 32'h0);
      step(REQ_STOP | REQ_START, `SMSEQ_SV_START);
      apb(`SMSEQ_OFF_CTRL, 1'b1, BASE | REQ_STOP);
      poll(`SMSEQ_OFF_STAT, `SMSEQ_STAT_MASTER, 1'b0);
    end
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_write;
    t_read;
    report_and_stop;
  end
endmodule // tb_top
